// [include/ats_pkg.sv]
// Purpose: Shared constants and types of the sequencer trigger and underflow register bank.
// Assumes: Plain register port with 8-bit byte addresses and 32-bit data.
// Notes: Every offset, field position and encoding, and every reset value but that of the interrupt status, is named here once.
package ats_pkg;

  // ****************************************************************
  // Sizes and register offsets
  // ****************************************************************
  localparam int unsigned NUM_SEQ = 4;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] OFS_SEQ_ENABLE = 8'h00;
  localparam logic [7:0] OFS_TRIG_EVENT_SELECT = 8'h14;
  localparam logic [7:0] OFS_FIFO_UNDERFLOW_FLAGS = 8'h18;
  localparam logic [7:0] OFS_SEQUENCER_PRIORITY = 8'h20;
  localparam logic [7:0] OFS_SAMPLE_INITIATE = 8'h28;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h40;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h44;

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int unsigned TRIG_FIELD_W = 4;
  localparam int unsigned PRIO_FIELD_W = 2;
  localparam int unsigned PRIO_FIELD_STRIDE = 4;
  localparam int unsigned IRQ_UF_LSB = 0;
  localparam int unsigned IRQ_START_LSB = 4;
  localparam int unsigned IRQ_W = 8;
  localparam logic [15:0] TRIG_EVENT_SELECT_RST = 16'h0000;
  localparam logic [7:0] SEQ_PRIO_RST = 8'hE4;
  localparam logic [3:0] UNDERFLOW_RST = 4'h0;
  localparam logic [3:0] SEQ_ENABLE_RST = 4'h0;
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;

  // ****************************************************************
  // Trigger source encodings
  // ****************************************************************
  typedef enum logic [3:0] {
    TRIG_PROCESSOR = 4'h0,
    TRIG_EXTERNAL = 4'h4,
    TRIG_TIMER = 4'h5,
    TRIG_PWM_A = 4'h6,
    TRIG_PWM_B = 4'h7,
    TRIG_PWM_C = 4'h8,
    TRIG_ALWAYS = 4'hF
  } ats_trig_src_e;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ats_bus_req_s;

  typedef struct packed {
    logic external_trigger_pin;
    logic timer_trigger;
    logic pwm_gen_a_trigger;
    logic pwm_gen_b_trigger;
    logic pwm_gen_c_trigger;
  } ats_trig_in_s;

  typedef struct packed {
    logic req;
    logic [1:0] seq;
  } ats_fifo_rd_s;

endpackage

// [verilog/ats_top.sv]
// Purpose: Per-sequencer trigger selection, start ordering and result FIFO underflow flags.
// Assumes: All inputs synchronous to clock; FIFO storage and converter live outside.
// Notes: Result reads answer one cycle after the request; starts come two cycles after the trigger.
`timescale 1ns/100ps

// How it works
// - Four 4-bit trigger fields, one per sequencer.
// - Field value picks processor, pin, timer, PWM, always.
// - All four fields decode identically.
// - Empty FIFO read sets that sequencer's underflow flag.
// - Underflow read returns zero, pointers unchanged.
// - Writing one clears exactly those underflow flags.
// - Processor initiate write starts enabled sequencer.
// - Simultaneous triggers run in priority order.
module ats_top
  import ats_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire ats_bus_req_s bus_req,
  output logic [31:0] bus_rdata,
  input wire ats_trig_in_s trig_in,
  input wire ats_fifo_rd_s fifo_rd,
  input wire logic [3:0] fifo_empty,
  input wire logic [31:0] fifo_head_data,
  output logic [3:0] fifo_pop,
  output logic [31:0] fifo_read_data,
  output logic fifo_read_valid,
  output logic [3:0] seq_start,
  output logic irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [3:0][3:0] trig_sel;
    logic [3:0][1:0] prio;
    logic [3:0] enable;
    logic [3:0] underflow;
    logic [3:0] pending;
    logic [3:0] seq_start;
    logic [3:0] fifo_pop;
    logic [31:0] fifo_data;
    logic fifo_valid;
    logic [31:0] rdata;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic irq;
  } ats_state_s;

  ats_state_s st_reg;
  ats_state_s st_next;
  logic [3:0] trig_hit;
  logic [3:0] grant;
  logic [3:0] uf_evt;
  logic [3:0] uf_clear;
  logic [7:0] irq_clear;
  logic wr_init;

  assign bus_rdata = st_reg.rdata;
  assign fifo_pop = st_reg.fifo_pop;
  assign fifo_read_data = st_reg.fifo_data;
  assign fifo_read_valid = st_reg.fifo_valid;
  assign seq_start = st_reg.seq_start;
  assign irq = st_reg.irq;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    st_next = st_reg;
    st_next.seq_start = 4'h0;
    st_next.fifo_pop = 4'h0;
    st_next.fifo_data = 32'h0000_0000;
    st_next.fifo_valid = 1'b0;
    st_next.rdata = 32'h0000_0000;
    trig_hit = 4'h0;
    grant = 4'h0;
    uf_evt = 4'h0;
    uf_clear = 4'h0;
    irq_clear = 8'h00;
    wr_init = bus_req.wr && (bus_req.addr == OFS_SAMPLE_INITIATE);

    // Every sequencer decodes its own field through the same table.
    for (int i = 0; i < NUM_SEQ; i++)
    begin
      case (st_reg.trig_sel[i])
        TRIG_PROCESSOR: trig_hit[i] = wr_init && bus_req.wdata[i];
        TRIG_EXTERNAL: trig_hit[i] = trig_in.external_trigger_pin;
        TRIG_TIMER: trig_hit[i] = trig_in.timer_trigger;
        TRIG_PWM_A: trig_hit[i] = trig_in.pwm_gen_a_trigger;
        TRIG_PWM_B: trig_hit[i] = trig_in.pwm_gen_b_trigger;
        TRIG_PWM_C: trig_hit[i] = trig_in.pwm_gen_c_trigger;
        TRIG_ALWAYS: trig_hit[i] = 1'b1;
        default: trig_hit[i] = 1'b0;
      endcase
    end
    trig_hit = trig_hit & st_reg.enable;

    // One start per cycle: the pending sequencer with the lowest priority code wins.
    for (int i = 0; i < NUM_SEQ; i++)
    begin
      grant[i] = st_reg.pending[i];
      for (int j = 0; j < NUM_SEQ; j++)
      begin
        if (st_reg.pending[j] && (j != i) && ((st_reg.prio[j] < st_reg.prio[i]) ||
            ((st_reg.prio[j] == st_reg.prio[i]) && (j < i))))
        begin
          grant[i] = 1'b0;
        end
      end
    end
    st_next.seq_start = grant;
    st_next.pending = (st_reg.pending & ~grant) | trig_hit;

    // Result reads: an empty FIFO is not popped and yields zero.
    if (fifo_rd.req)
    begin
      st_next.fifo_valid = 1'b1;
      if (fifo_empty[fifo_rd.seq])
      begin
        uf_evt[fifo_rd.seq] = 1'b1;
        st_next.fifo_data = 32'h0000_0000;
      end
      else
      begin
        st_next.fifo_pop[fifo_rd.seq] = 1'b1;
        st_next.fifo_data = fifo_head_data;
      end
    end

    // Register writes; reserved bits are not stored.
    if (bus_req.wr)
    begin
      case (bus_req.addr)
        OFS_SEQ_ENABLE: st_next.enable = bus_req.wdata[3:0];
        OFS_TRIG_EVENT_SELECT: st_next.trig_sel = bus_req.wdata[15:0];
        OFS_FIFO_UNDERFLOW_FLAGS: uf_clear = bus_req.wdata[3:0];
        OFS_SEQUENCER_PRIORITY:
        begin
          for (int i = 0; i < NUM_SEQ; i++)
          begin
            st_next.prio[i] = bus_req.wdata[i * PRIO_FIELD_STRIDE +: PRIO_FIELD_W];
          end
        end
        OFS_IRQ_STATUS: irq_clear = bus_req.wdata[7:0];
        OFS_IRQ_MASK: st_next.irq_mask = bus_req.wdata[7:0];
        default: st_next.enable = st_reg.enable;
      endcase
    end

    // A new event in the clearing cycle keeps its flag set.
    st_next.underflow = (st_reg.underflow & ~uf_clear) | uf_evt;
    st_next.irq_status = (st_reg.irq_status & ~irq_clear) | {grant, uf_evt};
    st_next.irq = |(st_next.irq_status & st_next.irq_mask);

    // Register reads; reserved and unmapped bits read as zero.
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        OFS_SEQ_ENABLE: st_next.rdata = {28'h0, st_reg.enable};
        OFS_TRIG_EVENT_SELECT: st_next.rdata = {16'h0, st_reg.trig_sel};
        OFS_FIFO_UNDERFLOW_FLAGS: st_next.rdata = {28'h0, st_reg.underflow};
        OFS_SEQUENCER_PRIORITY:
        begin
          for (int i = 0; i < NUM_SEQ; i++)
          begin
            st_next.rdata[i * PRIO_FIELD_STRIDE +: PRIO_FIELD_W] = st_reg.prio[i];
          end
        end
        OFS_IRQ_STATUS: st_next.rdata = {24'h0, st_reg.irq_status};
        OFS_IRQ_MASK: st_next.rdata = {24'h0, st_reg.irq_mask};
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      st_reg <= '0;
      st_reg.trig_sel <= TRIG_EVENT_SELECT_RST;
      st_reg.prio <= SEQ_PRIO_RST;
      st_reg.enable <= SEQ_ENABLE_RST;
      st_reg.underflow <= UNDERFLOW_RST;
      st_reg.irq_mask <= IRQ_MASK_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_trig_store;
    @(posedge clock) disable iff (!rst_b)
    bus_req.wr && (bus_req.addr == OFS_TRIG_EVENT_SELECT) |=>
      st_reg.trig_sel == $past(bus_req.wdata[15:0]);
  endproperty
  a_trig_store: assert property (p_trig_store)
    else $error("Trigger select field not stored.");

  property p_ext_pending;
    @(posedge clock) disable iff (!rst_b)
    trig_in.external_trigger_pin && (st_reg.trig_sel[0] == TRIG_EXTERNAL) && st_reg.enable[0]
      |=> st_reg.pending[0];
  endproperty
  a_ext_pending: assert property (p_ext_pending)
    else $error("External trigger did not arm sequencer 0.");

  property p_same_decode;
    @(posedge clock) disable iff (!rst_b)
    (st_reg.trig_sel[0] == st_reg.trig_sel[3]) && (st_reg.enable[0] == st_reg.enable[3]) &&
      (!wr_init || (bus_req.wdata[0] == bus_req.wdata[3]))
      |-> trig_hit[0] == trig_hit[3];
  endproperty
  a_same_decode: assert property (p_same_decode)
    else $error("Sequencers with equal settings decode differently.");

  property p_uf_set;
    @(posedge clock) disable iff (!rst_b)
    fifo_rd.req && fifo_empty[fifo_rd.seq] |=>
      st_reg.underflow[$past(fifo_rd.seq)] ##1 1'b1;
  endproperty
  a_uf_set: assert property (p_uf_set)
    else $error("Underflow flag not set on empty read.");

  property p_uf_zero;
    @(posedge clock) disable iff (!rst_b)
    fifo_rd.req && fifo_empty[fifo_rd.seq] |=>
      fifo_read_valid && (fifo_read_data == 32'h0000_0000) && (fifo_pop == 4'h0);
  endproperty
  a_uf_zero: assert property (p_uf_zero)
    else $error("Underflow read popped or returned data.");

  property p_uf_clear;
    @(posedge clock) disable iff (!rst_b)
    bus_req.wr && (bus_req.addr == OFS_FIFO_UNDERFLOW_FLAGS) && !fifo_rd.req |=>
      st_reg.underflow == ($past(st_reg.underflow) & ~$past(bus_req.wdata[3:0]));
  endproperty
  a_uf_clear: assert property (p_uf_clear)
    else $error("Underflow clear did not act on exactly the written ones.");

  property p_uf_keep;
    @(posedge clock) disable iff (!rst_b)
    !(bus_req.wr && (bus_req.addr == OFS_FIFO_UNDERFLOW_FLAGS)) |=>
      (st_reg.underflow & $past(st_reg.underflow)) == $past(st_reg.underflow);
  endproperty
  a_uf_keep: assert property (p_uf_keep)
    else $error("Underflow flag dropped without a clearing write.");

  property p_init_start;
    @(posedge clock) disable iff (!rst_b)
    wr_init && bus_req.wdata[0] && (st_reg.trig_sel[0] == TRIG_PROCESSOR) && st_reg.enable[0]
      |=> st_reg.pending[0] ##[1:4] seq_start[0];
  endproperty
  a_init_start: assert property (p_init_start)
    else $error("Processor initiate did not start sequencer 0.");

  property p_one_start;
    @(posedge clock) disable iff (!rst_b)
    (st_reg.pending[0] && st_reg.pending[1] && (st_reg.prio[0] < st_reg.prio[1]))
      |=> $onehot(seq_start) && seq_start[0];
  endproperty
  a_one_start: assert property (p_one_start)
    else $error("Lower priority sequencer started first.");

  property p_irq_level;
    @(posedge clock) disable iff (!rst_b)
    ##1 irq == |($past(st_next.irq_status) & $past(st_next.irq_mask));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("Interrupt output disagrees with status and mask.");

endmodule

// [tb/tb_top.sv]
// Purpose: Self-checking bench of the trigger select and underflow register bank.
// Assumes: Register port answers reads one cycle after the strobe, never stalls.
// Notes: Reset case first, then register rows, trigger, priority, underflow, interrupt and reset cases.
`timescale 1ns/100ps
module tb_top
  import ats_pkg::*;
;
  logic clock;
  logic rst_b;
  ats_bus_req_s bus_req;
  logic [31:0] bus_rdata;
  ats_trig_in_s trig_in;
  ats_fifo_rd_s fifo_rd;
  logic [3:0] fifo_empty;
  logic [31:0] fifo_head_data;
  logic [3:0] fifo_pop;
  logic [31:0] fifo_read_data;
  logic fifo_read_valid;
  logic [3:0] seq_start;
  logic irq;
  int miscompares;
  int compares;
  logic [31:0] rd;
  logic [3:0] acc;
  logic [3:0] f1;
  logic [3:0] f2;
  typedef struct packed {logic [7:0] addr; logic [31:0] wdata; logic [31:0] exp;} ats_row_s;
  localparam ats_row_s ROWS [8] = '{
    '{8'h14, 32'h0000_8765, 32'h0000_8765}, '{8'h14, 32'h0000_F40F, 32'h0000_F40F},
    '{8'h20, 32'h0000_0123, 32'h0000_0123}, '{8'h20, 32'h0000_3210, 32'h0000_3210},
    '{8'h28, 32'h0000_0000, 32'h0000_0000}, '{8'h3C, 32'h0000_005A, 32'h0000_0000},
    '{8'h44, 32'h0000_00FF, 32'h0000_00FF}, '{8'h14, 32'h0000_0000, 32'h0000_0000}};
  localparam logic [3:0] CODES [5] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8};

  ats_top i_ats_top (.clock(clock), .rst_b(rst_b), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .trig_in(trig_in), .fifo_rd(fifo_rd), .fifo_empty(fifo_empty),
    .fifo_head_data(fifo_head_data), .fifo_pop(fifo_pop), .fifo_read_data(fifo_read_data),
    .fifo_read_valid(fifo_read_valid), .seq_start(seq_start), .irq(irq));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus_req.wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus_req.rd <= 1'b0;
    #1 d = bus_rdata;
  endtask

  // Collects the start pulses of six cycles: the union and the first two seen.
  task automatic watch();
    acc = 4'h0;
    f1 = 4'h0;
    f2 = 4'h0;
    repeat (6)
    begin
      @(posedge clock);
      #1;
      if (seq_start !== 4'h0)
      begin
        if (f1 === 4'h0)
          f1 = seq_start;
        else if (f2 === 4'h0)
          f2 = seq_start;
        acc = acc | seq_start;
      end
    end
  endtask

  task automatic pulse(input logic [4:0] bits);
    @(posedge clock);
    trig_in <= bits;
    @(posedge clock);
    trig_in <= 5'h00;
    watch();
  endtask

  task automatic fread(input logic [1:0] s, input logic [3:0] emp, input logic [31:0] head);
    @(posedge clock);
    fifo_rd <= '{req: 1'b1, seq: s};
    fifo_empty <= emp;
    fifo_head_data <= head;
    @(posedge clock);
    fifo_rd <= '0;
    #1 chk("fifo_read_valid", {31'h0, fifo_read_valid}, 32'h1);
    chk("fifo_read_data", fifo_read_data, emp[s] ? 32'h0 : head);
    chk("fifo_pop", {28'h0, fifo_pop}, emp[s] ? 32'h0 : 32'h1 << s);
  endtask

  task automatic reset_check();
    rst_b <= 1'b0;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    bus_rd(8'h14, rd);
    chk("trigger_event_select", rd, 32'h0);
    bus_rd(8'h18, rd);
    chk("fifo_underflow_flags", rd, 32'h0);
    bus_rd(8'h20, rd);
    chk("sequencer_priority", rd, 32'h0000_3210);
    bus_rd(8'h44, rd);
    chk("irq_mask", rd, 32'h0);
    chk("irq after reset", {31'h0, irq}, 32'h0);
  endtask

  initial
  begin
    repeat (20000) @(posedge clock);
    miscompares++;
    wrap_up();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    rst_b = 1'b0;
    bus_req = '0;
    trig_in = '0;
    fifo_rd = '0;
    fifo_empty = 4'hF;
    fifo_head_data = 32'h0;
    miscompares = 0;
    compares = 0;
    reset_check();
    foreach (ROWS[i])
    begin
      bus_wr(ROWS[i].addr, ROWS[i].wdata);
      bus_rd(ROWS[i].addr, rd);
      chk("register row", rd, ROWS[i].exp);
    end
    bus_wr(8'h00, 32'h0000_000F);
    for (int i = 0; i < 5; i++)
    begin
      bus_wr(8'h14, 32'(CODES[i]) << (4 * (i % 4)));
      pulse(5'h10 >> i);
      chk("start by source", {28'h0, acc}, 32'h1 << (i % 4));
      pulse(~(5'h10 >> i));
      chk("other sources ignored", {28'h0, acc}, 32'h0);
    end
    bus_wr(8'h14, 32'h0000_1111);
    pulse(5'h1F);
    chk("reserved code", {28'h0, acc}, 32'h0);
    bus_wr(8'h14, 32'h0000_0000);
    bus_wr(8'h28, 32'h0000_0003);
    watch();
    chk("first start", {28'h0, f1}, 32'h1);
    chk("second start", {28'h0, f2}, 32'h2);
    bus_wr(8'h20, 32'h0000_3201);
    bus_wr(8'h28, 32'h0000_0003);
    watch();
    chk("swapped first", {28'h0, f1}, 32'h2);
    chk("swapped second", {28'h0, f2}, 32'h1);
    bus_wr(8'h20, 32'h0000_3210);
    bus_wr(8'h00, 32'h0000_0000);
    bus_wr(8'h28, 32'h0000_000F);
    watch();
    chk("disabled start", {28'h0, acc}, 32'h0);
    bus_wr(8'h00, 32'h0000_0008);
    bus_wr(8'h14, 32'h0000_F000);
    watch();
    chk("continuous first", {28'h0, f1}, 32'h8);
    chk("continuous again", {28'h0, f2}, 32'h8);
    bus_wr(8'h14, 32'h0000_0000);
    repeat (4) @(posedge clock);
    bus_wr(8'h40, 32'h0000_00FF);
    bus_wr(8'h44, 32'h0000_0001);
    fread(2'd2, 4'h4, 32'hDEAD_BEEF);
    fread(2'd1, 4'h4, 32'h1234_5678);
    fread(2'd0, 4'hF, 32'hCAFE_0001);
    bus_rd(8'h18, rd);
    chk("underflow flags", rd, 32'h0000_0005);
    chk("irq raised", {31'h0, irq}, 32'h1);
    bus_wr(8'h18, 32'h0000_0004);
    bus_rd(8'h18, rd);
    chk("one flag cleared", rd, 32'h0000_0001);
    bus_wr(8'h40, 32'h0000_0001);
    #1 chk("irq cleared", {31'h0, irq}, 32'h0);
    fread(2'd3, 4'h8, 32'h0);
    chk("irq masked", {31'h0, irq}, 32'h0);
    bus_rd(8'h18, rd);
    chk("flags kept", rd, 32'h0000_0009);
    // A clearing write and an empty read of the same sequencer in one cycle.
    @(posedge clock);
    bus_req <= '{addr: 8'h18, wdata: 32'h0000_0009, wr: 1'b1, rd: 1'b0};
    fifo_rd <= '{req: 1'b1, seq: 2'd0};
    fifo_empty <= 4'hF;
    @(posedge clock);
    bus_req.wr <= 1'b0;
    fifo_rd <= '0;
    bus_rd(8'h18, rd);
    chk("set beats clear", rd, 32'h0000_0001);
    reset_check();
    wrap_up();
  end
endmodule
